// ---- rtl/pps_regs.svh ----
// pps_regs.svh: register codes, host register addresses and field positions
// assumes: included by both ends and the bench, definitions only
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH
`define PPS_MODE_NORMAL 8'h09
`define PPS_MODE_PIPE_INIT 8'h08
`define PPS_MODE_CALIBRATE 8'h29
`define PPS_ADDR_PIXEL_MASK 8'h04
`define PPS_MASK_ALL 8'hFF
`define PPS_MODE_RESET 8'h09
`define PPS_MASK_RESET 8'hFF
`define PPS_ADDR_RESET 8'h00
`define PPS_MATCH_LO_BIT 6
`define PPS_MATCH_HI_BIT 7
`define PPS_PIPE_INIT_BIT 0
`define PPS_CAL_BIT 5
`define PPS_CAL_LEN 4'h8
`define PPS_ZERO_CURRENT 8'h00
// host registers of the controller, word addresses on the bus
`define PPS_HR_CTRL 4'h0
`define PPS_HR_STATUS 4'h1
`define PPS_HR_MODE 4'h2
`define PPS_HR_MASK 4'h3
`define PPS_CTRL_START_BIT 0
`endif

// ---- rtl/pps_pkg.sv ----
// pps_pkg.sv: shared types of the palette select block
// assumes: pps_regs.svh holds the numeric constants
package pps_pkg;
  typedef enum logic [1:0] {
    PPS_PORT_ADDR = 2'b00,
    PPS_PORT_MASK = 2'b10,
    PPS_PORT_RAM = 2'b01,
    PPS_PORT_MODE = 2'b11
  } pps_port_t;
endpackage

// ---- rtl/pps_if.sv ----
// pps_if.sv: link between the palette device and its host/window logic
// assumes: one clock; device samples strobes and pixels on clk
`timescale 1ns/1ps
interface pps_if;
  logic ctrl_sel_hi;
  logic ctrl_sel_lo;
  logic rd_wr;
  logic wr_strobe;
  logic [7:0] data;
  logic [1:0] palette_sel_lo;
  logic [1:0] palette_sel_hi;
  logic [7:0] pixel_a;
  logic [7:0] pixel_b;
  logic load_clock_out;
  logic load_clock_in;
  modport device (
    input ctrl_sel_hi, ctrl_sel_lo, rd_wr, wr_strobe, data,
    input palette_sel_lo, palette_sel_hi, pixel_a, pixel_b, load_clock_in,
    output load_clock_out
  );
  modport host (
    output ctrl_sel_hi, ctrl_sel_lo, rd_wr, wr_strobe, data,
    output palette_sel_lo, palette_sel_hi, pixel_a, pixel_b, load_clock_in,
    input load_clock_out
  );
endinterface

// ---- rtl/pps_device.sv ----
// pps_device.sv: palette device end, mode register, mask, select pipeline
// assumes: host strobes are synchronous to clk; two pixels per word (2:1 mux)
//
// Behaviour
// RQ1: selected only when both selects match bits
// RQ2: unselected device drives zero current
// RQ3: selects multiplexed exactly like pixel data
// RQ4: system uses at most four distinct codes
// RQ5: window logic selects exactly one device
// RQ6: per pixel decision to drive outputs
// RQ7: host programs mode before display
// RQ8: mode write C1=C0=1, 09H normal
// RQ9: 08H then 09H resets pipeline
// RQ10: 29H then 09H calibrates load clock
// RQ11: address write C1=C0=0, 04H mask
// RQ12: C1=1 C0=0 write loads mask
// RQ13: select aligned with pixel latency
//
// Design decision made at the host end: the Wishbone slave port.
`timescale 1ns/1ps
`include "pps_regs.svh"
module pps_device import pps_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to host and window logic
  pps_if.device link,
  // analog current outputs, digital stand-ins
  output logic [7:0] red_current_out,
  output logic [7:0] green_current_out,
  output logic [7:0] blue_current_out,
  // status
  output logic selected,
  output logic calibrated,
  output logic [7:0] operating_mode_one,
  output logic [7:0] pixel_mask
);
  logic [7:0] mode_ff, nxt_mode;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] addr_ff, nxt_addr;
  logic [7:0] pa_ff, nxt_pa, pb_ff, nxt_pb;
  logic [1:0] sa_ff, nxt_sa, sb_ff, nxt_sb;
  logic phase_ff, nxt_phase;
  logic [7:0] pix_ff, nxt_pix;
  logic sel_ff, nxt_sel;
  logic [3:0] cal_ff, nxt_cal;
  logic cal_done_ff, nxt_cal_done;
  logic lco_ff, nxt_lco;
  logic [7:0] r_ff, nxt_r, g_ff, nxt_g, b_ff, nxt_b;
  logic wr_mode, wr_addr, wr_mask;
  logic sel_out_ff, nxt_sel_out;
  logic arm_ff, nxt_arm;

  // match test, shared by both pixels of a word
  function automatic logic match(input logic [1:0] s, input logic [7:0] mode);
    match = (s[0] == mode[`PPS_MATCH_LO_BIT]) &&
            (s[1] == mode[`PPS_MATCH_HI_BIT]); // RQ1
  endfunction

  // host write qualifier: strobe, write direction and the wanted C1/C0 pair
  function automatic logic port_wr(input logic strobe, input logic rw,
                                   input logic [1:0] port, input pps_port_t want);
    port_wr = strobe && !rw && (port == want);
  endfunction

  // operation field of a mode value, the match code above it left out,
  // so a device with a nonzero code still sees the init and cal sequence
  function automatic logic [5:0] mode_op(input logic [7:0] v);
    mode_op = v[`PPS_MATCH_LO_BIT-1:0];
  endfunction

  // host port decode: write strobe with rd_wr low, port picked by C1/C0
  always_comb begin
    wr_mode = port_wr(link.wr_strobe, link.rd_wr, {link.ctrl_sel_hi, link.ctrl_sel_lo},
                      PPS_PORT_MODE); // RQ8
    wr_addr = port_wr(link.wr_strobe, link.rd_wr, {link.ctrl_sel_hi, link.ctrl_sel_lo},
                      PPS_PORT_ADDR); // RQ11
    wr_mask = port_wr(link.wr_strobe, link.rd_wr, {link.ctrl_sel_hi, link.ctrl_sel_lo},
                      PPS_PORT_MASK) && (addr_ff == `PPS_ADDR_PIXEL_MASK); // RQ12
  end

  // register file next state
  always_comb begin
    nxt_mode = wr_mode ? link.data : mode_ff; // RQ8
    nxt_addr = wr_addr ? link.data : addr_ff; // RQ11
    nxt_mask = wr_mask ? link.data : mask_ff; // RQ12
  end

  // calibration: a mode write with the cal bit loads a fixed training window;
  // the normal-mode write after it only arms completion, which lands once the
  // window has run and the looped-back load clock agrees, so a host that
  // sends normal mode at once does not cut the training short
  always_comb begin
    nxt_cal = cal_ff;
    nxt_cal_done = cal_done_ff;
    nxt_lco = lco_ff;
    nxt_arm = arm_ff;
    if (wr_mode && link.data[`PPS_CAL_BIT]) begin
      nxt_cal = `PPS_CAL_LEN; // RQ10
      nxt_cal_done = 1'b0;
      nxt_arm = 1'b0;
    end else begin
      if (cal_ff != 4'h0) begin
        nxt_cal = cal_ff - 4'h1;
        nxt_lco = ~lco_ff; // training toggles on load clock out
      end
      if (arm_ff && cal_ff == 4'h0 && link.load_clock_in == lco_ff) begin
        nxt_cal_done = 1'b1; // RQ10
        nxt_arm = 1'b0;
      end
      // a fresh arming request wins over the clear above
      if (wr_mode && mode_op(link.data) == mode_op(`PPS_MODE_NORMAL) &&
          mode_op(mode_ff) == mode_op(`PPS_MODE_CALIBRATE)) begin
        nxt_arm = 1'b1; // RQ10
      end
    end
  end

  // pixel and select capture, same path and same stage for both (2:1 mux);
  // pipe init (mode bit 0 low) clears phase to 0 and flushes the pipe
  always_comb begin
    nxt_pa = link.pixel_a;
    nxt_pb = link.pixel_b;
    nxt_sa = link.palette_sel_lo; // RQ3
    nxt_sb = link.palette_sel_hi; // RQ3
    nxt_phase = ~phase_ff;
    if (!mode_ff[`PPS_PIPE_INIT_BIT]) begin
      nxt_phase = 1'b0; // RQ9
      nxt_pa = `PPS_ZERO_CURRENT;
      nxt_pb = `PPS_ZERO_CURRENT;
    end
    nxt_pix = (phase_ff ? pb_ff : pa_ff) & mask_ff;
    nxt_sel = match(phase_ff ? sb_ff : sa_ff, mode_ff); // RQ6 RQ13
  end

  // output stage: selection registered in step with its pixel
  always_comb begin
    nxt_r = sel_ff ? pix_ff : `PPS_ZERO_CURRENT; // RQ2 RQ13
    nxt_g = sel_ff ? pix_ff : `PPS_ZERO_CURRENT; // RQ2
    nxt_b = sel_ff ? pix_ff : `PPS_ZERO_CURRENT; // RQ2
    nxt_sel_out = sel_ff; // RQ13
  end

  // host-written registers
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= `PPS_MODE_RESET;
      mask_ff <= `PPS_MASK_RESET;
      addr_ff <= `PPS_ADDR_RESET;
    end else begin
      mode_ff <= nxt_mode;
      mask_ff <= nxt_mask;
      addr_ff <= nxt_addr;
    end
  end

  // calibration state
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_ff <= 4'h0;
      cal_done_ff <= 1'b0;
      lco_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else begin
      cal_ff <= nxt_cal;
      cal_done_ff <= nxt_cal_done;
      lco_ff <= nxt_lco;
      arm_ff <= nxt_arm;
    end
  end

  // capture and pixel stage, selects beside their pixels
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_ff <= `PPS_ZERO_CURRENT;
      pb_ff <= `PPS_ZERO_CURRENT;
      sa_ff <= 2'h0;
      sb_ff <= 2'h0;
      phase_ff <= 1'b0;
      pix_ff <= `PPS_ZERO_CURRENT;
      sel_ff <= 1'b0;
    end else begin
      pa_ff <= nxt_pa;
      pb_ff <= nxt_pb;
      sa_ff <= nxt_sa;
      sb_ff <= nxt_sb;
      phase_ff <= nxt_phase;
      pix_ff <= nxt_pix;
      sel_ff <= nxt_sel;
    end
  end

  // output stage; selected travels with its pixel, so the flag never
  // claims a pixel that the current outputs do not carry
  always_ff @(posedge clk) begin
    if (rst) begin
      r_ff <= `PPS_ZERO_CURRENT;
      g_ff <= `PPS_ZERO_CURRENT;
      b_ff <= `PPS_ZERO_CURRENT;
      sel_out_ff <= 1'b0;
    end else begin
      r_ff <= nxt_r;
      g_ff <= nxt_g;
      b_ff <= nxt_b;
      sel_out_ff <= nxt_sel_out;
    end
  end

  // outputs straight from flip-flops
  assign red_current_out = r_ff;
  assign green_current_out = g_ff;
  assign blue_current_out = b_ff;
  assign selected = sel_out_ff;
  assign calibrated = cal_done_ff;
  assign operating_mode_one = mode_ff;
  assign pixel_mask = mask_ff;
  assign link.load_clock_out = lco_ff;
endmodule

// ---- rtl/pps_host.sv ----
// pps_host.sv: host end, runs the power-up sequence on a Wishbone command
// assumes: classic Wishbone slave, one clock, window selects from user side
`timescale 1ns/1ps
`include "pps_regs.svh"
module pps_host import pps_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // window logic user side
  input wire logic [1:0] win_sel_a,
  input wire logic [1:0] win_sel_b,
  input wire logic [7:0] win_pix_a,
  input wire logic [7:0] win_pix_b,
  // link
  pps_if.host link
);
  typedef enum logic [2:0] {
    PPS_S_IDLE = 3'b000, PPS_S_MODE = 3'b001, PPS_S_PINIT = 3'b010,
    PPS_S_PRUN = 3'b011, PPS_S_CAL = 3'b100, PPS_S_CRUN = 3'b101,
    PPS_S_ADDR = 3'b110, PPS_S_MASK = 3'b111
  } pps_state_t;
  pps_state_t st_ff, nxt_st;
  logic [7:0] mode_ff, nxt_mode, mask_ff, nxt_mask;
  logic done_ff, nxt_done, ack_ff, nxt_ack;
  logic [31:0] rd_ff, nxt_rd;
  logic c1, c0, stb;
  logic [7:0] dat;
  logic [1:0] sa_ff, sb_ff;
  logic [7:0] pa_ff, pb_ff;

  // the programmed match code rides in bits 7:6 of every mode write, else
  // the fixed init values would wipe it and every device would answer code 0
  function automatic logic [7:0] with_code(input logic [7:0] v, input logic [7:0] m);
    with_code = {m[`PPS_MATCH_HI_BIT:`PPS_MATCH_LO_BIT], v[`PPS_MATCH_LO_BIT-1:0]};
  endfunction

  // sequence step to port and value: C1/C0 and data for each state
  always_comb begin
    stb = 1'b1;
    c1 = 1'b1;
    c0 = 1'b1;
    dat = `PPS_MODE_NORMAL;
    case (st_ff)
      PPS_S_MODE: dat = mode_ff; // RQ8 RQ7 RQ4
      PPS_S_PINIT: dat = with_code(`PPS_MODE_PIPE_INIT, mode_ff); // RQ9
      PPS_S_PRUN: dat = with_code(`PPS_MODE_NORMAL, mode_ff); // RQ9
      PPS_S_CAL: dat = with_code(`PPS_MODE_CALIBRATE, mode_ff); // RQ10
      PPS_S_CRUN: dat = with_code(`PPS_MODE_NORMAL, mode_ff); // RQ10
      PPS_S_ADDR: begin
        c1 = 1'b0;
        c0 = 1'b0;
        dat = `PPS_ADDR_PIXEL_MASK; // RQ11
      end
      PPS_S_MASK: begin
        c0 = 1'b0;
        dat = mask_ff; // RQ12
      end
      default: stb = 1'b0;
    endcase
  end

  // one write per cycle through the sequence; start bit from software
  always_comb begin
    nxt_st = st_ff;
    nxt_done = done_ff;
    nxt_mode = mode_ff;
    nxt_mask = mask_ff;
    nxt_ack = 1'b0;
    nxt_rd = rd_ff;
    if (st_ff != PPS_S_IDLE) begin
      nxt_st = pps_state_t'(st_ff + 3'b001);
      if (st_ff == PPS_S_MASK) begin
        nxt_st = PPS_S_IDLE;
        nxt_done = 1'b1;
      end
    end
    if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      nxt_ack = 1'b1;
      nxt_rd = 32'h0000_0000;
      if (!wb_we_i) begin
        case (wb_adr_i)
          `PPS_HR_STATUS: nxt_rd = {30'h0, st_ff != PPS_S_IDLE, done_ff};
          `PPS_HR_MODE: nxt_rd = {24'h0, mode_ff};
          `PPS_HR_MASK: nxt_rd = {24'h0, mask_ff};
          default: nxt_rd = 32'h0000_0000;
        endcase
      end
    end
    // writes land at the edge where the master samples ack high, not earlier,
    // so a cycle dropped before its ack changes nothing
    if (wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        `PPS_HR_CTRL: begin
          if (wb_dat_i[`PPS_CTRL_START_BIT] && st_ff == PPS_S_IDLE) begin
            nxt_st = PPS_S_MODE; // RQ7
            nxt_done = 1'b0;
          end
        end
        `PPS_HR_MODE: nxt_mode = wb_dat_i[7:0];
        `PPS_HR_MASK: nxt_mask = wb_dat_i[7:0];
        default: nxt_rd = rd_ff;
      endcase
    end
  end

  // registers, window selects registered with their pixels
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= PPS_S_IDLE;
      mode_ff <= `PPS_MODE_NORMAL;
      mask_ff <= `PPS_MASK_ALL;
      done_ff <= 1'b0;
      ack_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      sa_ff <= 2'h0;
      sb_ff <= 2'h0;
      pa_ff <= 8'h00;
      pb_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      mode_ff <= nxt_mode;
      mask_ff <= nxt_mask;
      done_ff <= nxt_done;
      ack_ff <= nxt_ack;
      rd_ff <= nxt_rd;
      sa_ff <= win_sel_a; // RQ5
      sb_ff <= win_sel_b;
      pa_ff <= win_pix_a;
      pb_ff <= win_pix_b;
    end
  end

  // link drive; strobes are combinational from state flip-flops
  assign link.wr_strobe = stb;
  assign link.ctrl_sel_hi = c1;
  assign link.ctrl_sel_lo = c0;
  assign link.rd_wr = 1'b0;
  assign link.data = dat;
  assign link.palette_sel_lo = sa_ff;
  assign link.palette_sel_hi = sb_ff;
  assign link.pixel_a = pa_ff;
  assign link.pixel_b = pb_ff;
  assign link.load_clock_in = link.load_clock_out;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;
endmodule

// ---- tb/pps_sel_chk.sv ----
// pps_sel_chk.sv: checks on the link and the device outputs of the pair
// assumes: placed beside the link by the bench, one clock, sync reset
`timescale 1ns/1ps
module pps_sel_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host write port and selects
  input wire logic ctrl_sel_hi,
  input wire logic ctrl_sel_lo,
  input wire logic rd_wr,
  input wire logic wr_strobe,
  input wire logic [7:0] data,
  input wire logic [1:0] palette_sel_lo,
  input wire logic [1:0] palette_sel_hi,
  input wire logic load_clock_out,
  // device outputs
  input wire logic [7:0] red_current_out,
  input wire logic [7:0] green_current_out,
  input wire logic [7:0] blue_current_out,
  input wire logic selected,
  input wire logic [7:0] operating_mode_one,
  input wire logic [7:0] pixel_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic mode_wr, addr_wr, mask_wr, hit, miss;
  logic [3:0] hit_ff, miss_ff, nxt_hit, nxt_miss;
  // run lengths of steady match or miss, restarted by any write
  always_comb begin
    mode_wr = wr_strobe && !rd_wr && ctrl_sel_hi && ctrl_sel_lo;
    addr_wr = wr_strobe && !rd_wr && !ctrl_sel_hi && !ctrl_sel_lo;
    mask_wr = wr_strobe && !rd_wr && ctrl_sel_hi && !ctrl_sel_lo;
    hit = palette_sel_lo == operating_mode_one[7:6] && palette_sel_hi == operating_mode_one[7:6];
    miss = palette_sel_lo != operating_mode_one[7:6] && palette_sel_hi != operating_mode_one[7:6];
    nxt_hit = (wr_strobe || !hit) ? 4'h0 : hit_ff + {3'h0, hit_ff != 4'hF};
    nxt_miss = (wr_strobe || !miss) ? 4'h0 : miss_ff + {3'h0, miss_ff != 4'hF};
  end
  // registers only; six cycles cover the three-stage select pipeline
  always_ff @(posedge clk) begin
    hit_ff <= rst ? 4'h0 : nxt_hit;
    miss_ff <= rst ? 4'h0 : nxt_miss;
  end
  mode_load_a: assert property (mode_wr |=> operating_mode_one == $past(data))
    else $error("mode register missed a write");
  mask_load_a: assert property ((mask_wr && $past(addr_wr && data == 8'h04))
    |=> pixel_mask == $past(data)) else $error("pixel mask missed a write");
  pipe_seq_a: assert property (mode_wr && data[5:0] == 6'h08 |=>
    mode_wr && data[5:0] == 6'h09) else $error("pipeline init not followed by normal mode");
  cal_seq_a: assert property (mode_wr && data[5:0] == 6'h29 |=>
    mode_wr && data[5:0] == 6'h09) else $error("calibration not followed by normal mode");
  cal_clock_a: assert property (mode_wr && data[5] |-> ##[1:3] $changed(load_clock_out))
    else $error("load clock did not toggle on calibration");
  addr_seq_a: assert property (addr_wr && data == 8'h04 |=> mask_wr)
    else $error("mask address not followed by mask write");
  zero_cur_a: assert property (!selected |->
    red_current_out == 8'h00 && green_current_out == 8'h00 && blue_current_out == 8'h00)
    else $error("unselected device drives current");
  hit_sel_a: assert property (hit_ff >= 4'h6 |-> selected)
    else $error("matching selects left device unselected");
  miss_sel_a: assert property (miss_ff >= 4'h6 |-> !selected)
    else $error("mismatching selects left device selected");
endmodule

// ---- tb/palette_priority_select_and_init_bench.sv ----
// bench: host and device joined by the link, driven over Wishbone
// assumes: 25 MHz clock, reset held 16 cycles, no random stimulus
`timescale 1ns/1ps
`include "pps_regs.svh"
module palette_priority_select_and_init_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, selected, calibrated;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, wb_rd;
  logic [1:0] sel_a = 2'h0, sel_b = 2'h0;
  logic [7:0] pix_a = 8'hA5, pix_b = 8'h5A, red, green, blue, mode, mask, r1;
  int mismatches = 0, checked = 0;
  always #20 clk = ~clk;
  pps_if i_pps_if ();
  pps_device i_pps_device (.clk(clk), .rst(rst), .link(i_pps_if), .red_current_out(red),
    .green_current_out(green), .blue_current_out(blue), .selected(selected),
    .calibrated(calibrated), .operating_mode_one(mode), .pixel_mask(mask));
  pps_host i_pps_host (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_rd), .wb_ack_o(ack),
    .win_sel_a(sel_a), .win_sel_b(sel_b), .win_pix_a(pix_a), .win_pix_b(pix_b),
    .link(i_pps_if));
  pps_sel_chk i_pps_sel_chk (.clk(clk), .rst(rst), .ctrl_sel_hi(i_pps_if.ctrl_sel_hi),
    .ctrl_sel_lo(i_pps_if.ctrl_sel_lo), .rd_wr(i_pps_if.rd_wr),
    .wr_strobe(i_pps_if.wr_strobe), .data(i_pps_if.data),
    .palette_sel_lo(i_pps_if.palette_sel_lo), .palette_sel_hi(i_pps_if.palette_sel_hi),
    .load_clock_out(i_pps_if.load_clock_out), .red_current_out(red),
    .green_current_out(green), .blue_current_out(blue), .selected(selected),
    .operating_mode_one(mode), .pixel_mask(mask));
  task automatic give_verdict();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; held until ack is seen, released at that edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = wb_rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
  endtask
  // start the sequence and poll status until done; a stuck sequence ends the run
  task automatic run_seq();
    int n;
    wb(1'b1, `PPS_HR_CTRL, 32'h0000_0001);
    n = 0;
    do begin
      wb(1'b0, `PPS_HR_STATUS, 32'h0);
      n++;
    end while (rdat[0] !== 1'b1 && n < 30);
    chk(rdat, 32'h0000_0001);
    if (rdat[0] !== 1'b1) give_verdict();
  endtask
  // reset values, and an unmapped write that must change nothing
  task automatic t_reset();
    wb(1'b1, 4'hA, 32'h0000_0055);
    wb(1'b0, 4'hA, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b0, `PPS_HR_MODE, 32'h0);
    chk(rdat, 32'h0000_0009);
    chk({24'h0, mode}, 32'h0000_0009);
    chk({24'h0, mask}, 32'h0000_00FF);
  endtask
  // full power-up sequence with a partial mask, polled to completion
  task automatic t_init();
    wb(1'b1, `PPS_HR_MASK, 32'h0000_003C);
    run_seq();
    chk({24'h0, mode}, 32'h0000_0009);
    chk({24'h0, mask}, 32'h0000_003C);
    // training window outlasts the sequence, so allow it to finish
    repeat (8) @(posedge clk);
    chk({31'h0, calibrated}, 32'h1);
  endtask
  // a distinct match code survives the sequence; a swapped bit pair shows up
  task automatic t_code();
    wb(1'b1, `PPS_HR_MODE, 32'h0000_0049);
    run_seq();
    chk({24'h0, mode}, 32'h0000_0049);
    sel_a <= 2'h1;
    sel_b <= 2'h1;
    repeat (8) @(posedge clk);
    chk({31'h0, selected}, 32'h1);
    sel_a <= 2'h2;
    sel_b <= 2'h2;
    repeat (8) @(posedge clk);
    chk({31'h0, selected}, 32'h0);
    chk({24'h0, red}, 32'h0);
  endtask
  // whole-word selects: a match shows both masked pixels, others go dark
  task automatic t_match();
    sel_a <= 2'h0;
    sel_b <= 2'h0;
    repeat (8) @(posedge clk);
    r1 = red;
    @(posedge clk);
    chk({31'h0, selected}, 32'h1);
    chk({r1, red}, (r1 == 8'h24) ? 32'h2418 : 32'h1824);
    chk({green, blue}, (r1 == 8'h24) ? 32'h1818 : 32'h2424);
    for (int c = 1; c < 4; c++) begin
      sel_a <= c[1:0];
      sel_b <= c[1:0];
      repeat (8) @(posedge clk);
      chk({31'h0, selected}, 32'h0);
      chk({24'h0, red}, 32'h0);
    end
  endtask
  // selects differ between the two pixels of a word
  task automatic t_subpixel();
    sel_a <= 2'h0;
    sel_b <= 2'h2;
    repeat (8) @(posedge clk);
    r1 = red;
    @(posedge clk);
    chk({r1, red}, (r1 == 8'h24) ? 32'h2400 : 32'h0024);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_init();
    t_match();
    t_subpixel();
    t_code();
    give_verdict();
  end
endmodule
